/* hw/ppo_pkg.sv */
package ppo_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // sizes
   localparam int ADDR_W     = 14;
   localparam int DATA_W     = 32;
   localparam int CHANNELS   = 4;
   localparam int MAX_STEPS  = 250;
   localparam int STEP_WORDS = 9;
   localparam int PTR_FLD_W  = 8;
   localparam int HIGH_W     = 16;
   localparam int BASE_W     = 16;
   localparam int PH_W       = 10;

   ////////////////////////////////////////////////////////////////////////////
   // timing: both resolutions step the phase at 18.432 MHz / (divisor + 1)
   localparam int CLK_HZ        = 125000000;
   localparam int PWM_FREQ_100  = 184320;
   localparam int PWM_FREQ_1000 = 18432;
   localparam int PWM_RES_100   = 100;
   localparam int PWM_RES_1000  = 1000;
   localparam int ACC_SCALE     = 1000;
   localparam int ACC_W         = 18;
   localparam logic [ACC_W-1:0] ACC_INC =
      ACC_W'(PWM_FREQ_100 * PWM_RES_100 / ACC_SCALE);
   localparam logic [ACC_W-1:0] ACC_MOD  = ACC_W'(CLK_HZ / ACC_SCALE);
   localparam logic [PH_W-1:0]  LIM_100  = PH_W'(PWM_RES_100 - 1);
   localparam logic [PH_W-1:0]  LIM_1000 = PH_W'(PWM_RES_1000 - 1);

   ////////////////////////////////////////////////////////////////////////////
   // byte offsets
   localparam logic [ADDR_W-1:0] ADDR_CTRL   = 14'h0000;
   localparam logic [ADDR_W-1:0] ADDR_STAT   = 14'h0004;
   localparam logic [ADDR_W-1:0] ADDR_ERR    = 14'h0008;
   localparam logic [ADDR_W-1:0] ADDR_PAIR   = 14'h000c;
   localparam logic [ADDR_W-1:0] ADDR_HIGH01 = 14'h0010;
   localparam logic [ADDR_W-1:0] ADDR_HIGH23 = 14'h0014;
   localparam logic [ADDR_W-1:0] ADDR_BASE0  = 14'h0018;
   localparam logic [ADDR_W-1:0] ADDR_PTR    = 14'h0028;
   localparam logic [ADDR_W-1:0] ADDR_PROG   = 14'h0400;
   localparam logic [ADDR_W-1:0] REG_STRIDE  = 14'h0004;

   ////////////////////////////////////////////////////////////////////////////
   // step words and condition bits
   localparam int W_HALF     = 0;
   localparam int W_DIST     = 1;
   localparam int W_COND     = 2;
   localparam int COND_LAST  = 0;
   localparam int COND_CHAIN = 1;
   localparam int COND_DIR   = 2;

   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [7:0] ERR_ADDR = 8'h01;
   localparam logic [7:0] ERR_FREQ = 8'h02;
   localparam logic [7:0] ERR_DIST = 8'h03;
   localparam logic [7:0] ERR_MODE = 8'h04;

   localparam logic [31:0]       CTRL_RST = 32'h0000_0000;
   localparam logic [31:0]       PAIR_RST = 32'h0000_0000;
   localparam logic [HIGH_W-1:0] HIGH_RST = 16'h0000;
   localparam logic [BASE_W-1:0] BASE_RST = 16'h0000;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {
      MODE_PLAIN, MODE_UPDOWN, MODE_PULSEDIR, MODE_QUAD
   } ppo_mode_e;

   typedef struct packed {
      logic      level;
      logic      idle_hi;
      ppo_mode_e mode;
      logic      pwm_en;
      logic      cancel_request;
      logic      hold_request;
      logic      enable;
   } ppo_ctrl_s;

   typedef struct packed {
      logic step_complete_flag;
      logic fault;
      logic free;
      logic pulse_sending_flag;
   } ppo_stat_s;

   typedef struct packed {
      logic [2:0]  rsvd;
      logic        granularity_select;
      logic [11:0] period_divisor;
   } ppo_pair_s;

   typedef enum logic [2:0] {
      ST_IDLE, ST_WAIT, ST_LOAD, ST_RUN, ST_HOLD
   } ppo_chst_e;

endpackage

/* hw/ppo_pulse_output.sv */
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps

// Operation
// [RQ1] pwm pairs 0/1 and 2/3 share divisor and resolution; high time per channel
// [RQ2] pwm enable high drives a continuous pwm waveform on the first pin; the code drives it only while the channel is not in ST_RUN or ST_HOLD
// [RQ3] pwm rate is 184320 or 18432 over divisor plus one
// [RQ4] high time is setting times period over 100 or 1000
// [RQ5] program holds up to 250 steps: frequency, distance, next condition
// [RQ6] each step takes nine consecutive words from the program base
// [RQ7] host may rewrite the program area at any time with writes
// [RQ8] enable with channel free starts at the step after the last one
// [RQ9] after the final step the next start resumes at step zero
// [RQ10] channel owned elsewhere: wait, then take the pins once released
// [RQ11] enable low stops pulses on that channel at once
// [RQ12] hold request freezes pulses and keeps remaining travel
// [RQ13] hold released with enable high resumes the unfinished pulses
// [RQ14] cancel stops pulses at once and resets the step pointer
// [RQ15] pulse sending flag is high exactly while pulses are emitted
// [RQ16] execution error sets fault and stores an error code
// [RQ17] step complete flag is set whenever a step finishes
// [RQ18] free flag clears while a program owns the channel
// [RQ19] pin pair runs up/down, pulse/direction or quadrature; else plain; the code rejects MODE_PLAIN at load with ERR_MODE
// [RQ20] pulse idle level selectable high or low
module ppo_pulse_output #(
   parameter int MAX_STEPS  = ppo_pkg::MAX_STEPS,
   parameter int PROG_WORDS = ppo_pkg::MAX_STEPS * ppo_pkg::STEP_WORDS
) (
   input  wire logic        CLK_IN,             // 125 MHz clock
   input  wire logic        RST_B_IN,           // sync reset, active low
   input  wire logic [13:0] S_AXI_AWADDR_IN,    // write address
   input  wire logic        S_AXI_AWVALID_IN,   // write address valid
   output logic             S_AXI_AWREADY_OUT,  // write address ready
   input  wire logic [31:0] S_AXI_WDATA_IN,     // write data
   input  wire logic [3:0]  S_AXI_WSTRB_IN,     // byte strobes
   input  wire logic        S_AXI_WVALID_IN,    // write data valid
   output logic             S_AXI_WREADY_OUT,   // write data ready
   output logic [1:0]       S_AXI_BRESP_OUT,    // write response
   output logic             S_AXI_BVALID_OUT,   // write response valid
   input  wire logic        S_AXI_BREADY_IN,    // write response ready
   input  wire logic [13:0] S_AXI_ARADDR_IN,    // read address
   input  wire logic        S_AXI_ARVALID_IN,   // read address valid
   output logic             S_AXI_ARREADY_OUT,  // read address ready
   output logic [31:0]      S_AXI_RDATA_OUT,    // read data
   output logic [1:0]       S_AXI_RRESP_OUT,    // read response
   output logic             S_AXI_RVALID_OUT,   // read data valid
   input  wire logic        S_AXI_RREADY_IN,    // read data ready
   input  wire logic [3:0]  EXT_OWNER_IN,       // channel owned elsewhere
   output logic [7:0]       PULSE_PIN_OUT       // two pins per channel
);

   localparam int AW    = ppo_pkg::ADDR_W;
   localparam int NCH   = ppo_pkg::CHANNELS;
   localparam int WIDX  = $clog2(PROG_WORDS);
   localparam int PTR_W = $clog2(MAX_STEPS);
   localparam int SA_W  = 17;
   localparam logic [AW-3:0] PROG_LIM = (AW-2)'(PROG_WORDS);

   if (PTR_W > ppo_pkg::PTR_FLD_W || MAX_STEPS < 2 ||
       PROG_WORDS < ppo_pkg::STEP_WORDS ||
       PROG_WORDS * 4 + int'(ppo_pkg::ADDR_PROG) > 2 ** AW) begin : g_chk
      $error("ppo_pulse_output: unsupported program size");
   end

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // register bus
   logic [AW-1:0] aw_addr_q;
   logic          aw_have_q;
   logic          awready_q;
   logic [31:0]   w_data_q;
   logic [3:0]    w_strb_q;
   logic          w_have_q;
   logic          wready_q;
   logic          bvalid_q;
   logic [1:0]    bresp_q;
   logic          arready_q;
   logic          rvalid_q;
   logic [31:0]   rdata_q;
   logic [1:0]    rresp_q;

   ppo_pkg::ppo_ctrl_s [NCH-1:0]   ctrl_q;
   ppo_pkg::ppo_pair_s [1:0]       pair_q;
   logic [NCH-1:0][ppo_pkg::HIGH_W-1:0] high_q;
   logic [ppo_pkg::BASE_W-1:0]     base_q [NCH];
   logic [31:0]                    mem_q [PROG_WORDS];
   ppo_pkg::ppo_stat_s [NCH-1:0]   stat_w;
   logic [NCH-1:0][7:0]            err_w;
   logic [NCH-1:0][7:0]            ptr_w;
   logic [NCH-1:0]                 pwm_w;
   logic [7:0]                     pin_d;

   wire do_write = aw_have_q & w_have_q & ~bvalid_q;
   wire [AW-1:0] pw_off = aw_addr_q - ppo_pkg::ADDR_PROG;
   wire pw_ok = (aw_addr_q >= ppo_pkg::ADDR_PROG) &&
                (aw_addr_q[1:0] == 2'b00) &&
                (pw_off[AW-1:2] < PROG_LIM);
   wire wr_ctrl = do_write && aw_addr_q == ppo_pkg::ADDR_CTRL;
   wire wr_stat = do_write && aw_addr_q == ppo_pkg::ADDR_STAT;
   wire wr_pair = do_write && aw_addr_q == ppo_pkg::ADDR_PAIR;
   wire wr_h01  = do_write && aw_addr_q == ppo_pkg::ADDR_HIGH01;
   wire wr_h23  = do_write && aw_addr_q == ppo_pkg::ADDR_HIGH23;
   wire [AW-1:0] bw_off = aw_addr_q - ppo_pkg::ADDR_BASE0;
   wire wr_base = do_write && aw_addr_q[1:0] == 2'b00 &&
                  aw_addr_q >= ppo_pkg::ADDR_BASE0 &&
                  aw_addr_q < ppo_pkg::ADDR_PTR;
   wire wr_known = (aw_addr_q <= ppo_pkg::ADDR_PTR &&
                    aw_addr_q[1:0] == 2'b00) || pw_ok;
   wire [31:0] stat_clr = (wr_stat) ? merge(32'h0, w_data_q, w_strb_q)
                                    : 32'h0;
   wire [31:0] ctrl_wr = merge(32'(ctrl_q), w_data_q, w_strb_q);
   wire [31:0] pair_wr = merge(32'(pair_q), w_data_q, w_strb_q);
   wire [31:0] h01_wr  = merge(32'(high_q[1:0]), w_data_q, w_strb_q);
   wire [31:0] h23_wr  = merge(32'(high_q[3:2]), w_data_q, w_strb_q);
   wire [31:0] reg_any_clr = {NCH{8'b1111_1011}};

   // read decode
   wire [AW-1:0] ar_off = S_AXI_ARADDR_IN - ppo_pkg::ADDR_PROG;
   wire ar_prog = (S_AXI_ARADDR_IN >= ppo_pkg::ADDR_PROG) &&
                  (S_AXI_ARADDR_IN[1:0] == 2'b00) &&
                  (ar_off[AW-1:2] < PROG_LIM);
   wire [AW-1:0] ab_off = S_AXI_ARADDR_IN - ppo_pkg::ADDR_BASE0;
   wire ar_base = S_AXI_ARADDR_IN >= ppo_pkg::ADDR_BASE0 &&
                  S_AXI_ARADDR_IN < ppo_pkg::ADDR_PTR;
   wire ar_known = (S_AXI_ARADDR_IN <= ppo_pkg::ADDR_PTR &&
                    S_AXI_ARADDR_IN[1:0] == 2'b00) || ar_prog;
   wire [31:0] rd_w =
      ar_prog ? mem_q[ar_off[WIDX+1:2]] :
      ar_base ? 32'(base_q[ab_off[3:2]]) :
      (S_AXI_ARADDR_IN == ppo_pkg::ADDR_CTRL)   ? 32'(ctrl_q) :
      (S_AXI_ARADDR_IN == ppo_pkg::ADDR_STAT)   ? 32'(stat_w) :
      (S_AXI_ARADDR_IN == ppo_pkg::ADDR_ERR)    ? 32'(err_w) :
      (S_AXI_ARADDR_IN == ppo_pkg::ADDR_PAIR)   ? 32'(pair_q) :
      (S_AXI_ARADDR_IN == ppo_pkg::ADDR_HIGH01) ? 32'(high_q[1:0]) :
      (S_AXI_ARADDR_IN == ppo_pkg::ADDR_HIGH23) ? 32'(high_q[3:2]) :
      (S_AXI_ARADDR_IN == ppo_pkg::ADDR_PTR)    ? 32'(ptr_w) : 32'h0;

   always_ff @(posedge CLK_IN) begin
      if (!RST_B_IN) begin
         aw_have_q <= 1'b0;
         awready_q <= 1'b1;
         w_have_q  <= 1'b0;
         wready_q  <= 1'b1;
         bvalid_q  <= 1'b0;
         bresp_q   <= ppo_pkg::RESP_OKAY;
         aw_addr_q <= '0;
         w_data_q  <= 32'h0;
         w_strb_q  <= 4'h0;
      end else begin
         if (S_AXI_AWVALID_IN && awready_q) begin
            aw_addr_q <= S_AXI_AWADDR_IN;
            aw_have_q <= 1'b1;
            awready_q <= 1'b0;
         end else if (do_write) begin
            aw_have_q <= 1'b0;
         end
         if (S_AXI_WVALID_IN && wready_q) begin
            w_data_q <= S_AXI_WDATA_IN;
            w_strb_q <= S_AXI_WSTRB_IN;
            w_have_q <= 1'b1;
            wready_q <= 1'b0;
         end else if (do_write) begin
            w_have_q <= 1'b0;
         end
         if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_known ? ppo_pkg::RESP_OKAY : ppo_pkg::RESP_SLVERR;
         end else if (bvalid_q && S_AXI_BREADY_IN) begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_B_IN) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0;
         rresp_q   <= ppo_pkg::RESP_OKAY;
      end else if (S_AXI_ARVALID_IN && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= ar_known ? rd_w : 32'h0;
         rresp_q   <= ar_known ? ppo_pkg::RESP_OKAY : ppo_pkg::RESP_SLVERR;
      end else if (rvalid_q && S_AXI_RREADY_IN) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // settings; cancel bits last one cycle
   always_ff @(posedge CLK_IN) begin
      if (!RST_B_IN) begin
         ctrl_q <= ppo_pkg::CTRL_RST;
         pair_q <= ppo_pkg::PAIR_RST;
         high_q <= {NCH{ppo_pkg::HIGH_RST}};
         for (int c = 0; c < NCH; c++) begin
            base_q[c] <= ppo_pkg::BASE_RST;
         end
      end else begin
         ctrl_q <= wr_ctrl ? ctrl_wr : (32'(ctrl_q) & reg_any_clr); // see [RQ14]
         if (wr_pair) begin
            pair_q <= pair_wr;                                      // see [RQ1]
            pair_q[0].rsvd <= 3'b000;
            pair_q[1].rsvd <= 3'b000;
         end
         if (wr_h01) high_q[1:0] <= h01_wr;
         if (wr_h23) high_q[3:2] <= h23_wr;
         if (wr_base) base_q[bw_off[3:2]] <= w_data_q[ppo_pkg::BASE_W-1:0];
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (do_write && pw_ok) begin
         mem_q[pw_off[WIDX+1:2]] <=                                 // see [RQ7]
            merge(mem_q[pw_off[WIDX+1:2]], w_data_q, w_strb_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pwm: fractional base tick, one divider and phase per pair
   logic [ppo_pkg::ACC_W-1:0] acc_q;
   wire [ppo_pkg::ACC_W-1:0] acc_sum = acc_q + ppo_pkg::ACC_INC;
   wire base_tick = acc_sum >= ppo_pkg::ACC_MOD;

   always_ff @(posedge CLK_IN) begin
      if (!RST_B_IN) acc_q <= '0;
      else acc_q <= base_tick ? acc_sum - ppo_pkg::ACC_MOD : acc_sum;// see [RQ3]
   end

   for (genvar p = 0; p < 2; p++) begin : g_pair
      logic [11:0]           div_q;
      logic [ppo_pkg::PH_W-1:0] ph_q;
      wire step = base_tick && div_q == pair_q[p].period_divisor;
      wire [ppo_pkg::PH_W-1:0] lim = pair_q[p].granularity_select ?
                                     ppo_pkg::LIM_1000 : ppo_pkg::LIM_100;
      always_ff @(posedge CLK_IN) begin
         if (!RST_B_IN) begin
            div_q <= '0;
            ph_q  <= '0;
         end else begin
            if (base_tick) div_q <= step ? 12'h000 : div_q + 12'h001;
            if (step) ph_q <= (ph_q >= lim) ? '0 : ph_q + 1'b1;  // see [RQ3]
         end
      end
      for (genvar k = 0; k < 2; k++) begin : g_hi
         assign pwm_w[2*p+k] =                                  // see [RQ4]
            ppo_pkg::HIGH_W'(ph_q) < high_q[2*p+k];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // owner inputs from outside
   logic [NCH-1:0] own_s1_q;
   logic [NCH-1:0] own_s2_q;
   always_ff @(posedge CLK_IN) begin
      if (!RST_B_IN) begin
         own_s1_q <= '0;
         own_s2_q <= '0;
      end else begin
         own_s1_q <= EXT_OWNER_IN;
         own_s2_q <= own_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // positioning channels
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      ppo_pkg::ppo_chst_e st_q;
      logic [PTR_W-1:0] ptr_q;
      logic [31:0]      half_q;
      logic [31:0]      hcnt_q;
      logic [31:0]      dist_q;
      logic [2:0]       cond_q;
      logic [1:0]       ph_q;
      logic             en_prev_q;
      logic             fault_q;
      logic             done_q;
      logic [7:0]       err_q;

      ppo_pkg::ppo_ctrl_s cf;
      assign cf = ctrl_q[c];
      wire [SA_W-1:0] sa = SA_W'(base_q[c]) +                  // see [RQ6]
           SA_W'(ptr_q) * SA_W'(ppo_pkg::STEP_WORDS);
      wire sa_ok = sa <= SA_W'(PROG_WORDS - 3);
      wire [WIDX-1:0] ra = sa_ok ? sa[WIDX-1:0] : '0;
      wire [31:0] w_half = mem_q[ra + WIDX'(ppo_pkg::W_HALF)];  // see [RQ5]
      wire [31:0] w_dist = mem_q[ra + WIDX'(ppo_pkg::W_DIST)];
      wire [31:0] w_cond = mem_q[ra + WIDX'(ppo_pkg::W_COND)];
      wire [7:0] ld_err = !sa_ok ? ppo_pkg::ERR_ADDR :
                          (w_half == 32'h0) ? ppo_pkg::ERR_FREQ :
                          (w_dist == 32'h0) ? ppo_pkg::ERR_DIST :
                          (cf.mode == ppo_pkg::MODE_PLAIN) ?
                          ppo_pkg::ERR_MODE : ppo_pkg::ERR_NONE;
      wire start     = cf.enable & ~en_prev_q;
      wire run       = st_q == ppo_pkg::ST_RUN;
      wire half_tick = run && hcnt_q == 32'h1;
      wire pulse_end = half_tick && ph_q[0];
      wire step_end  = pulse_end && dist_q == 32'h1;
      wire last      = cond_q[ppo_pkg::COND_LAST] ||
                       ptr_q == PTR_W'(MAX_STEPS - 1);
      wire ld_fail   = st_q == ppo_pkg::ST_LOAD &&
                       ld_err != ppo_pkg::ERR_NONE;

      always_ff @(posedge CLK_IN) begin
         if (!RST_B_IN) begin
            st_q <= ppo_pkg::ST_IDLE;
            ptr_q <= '0;
            half_q <= 32'h0;
            hcnt_q <= 32'h0;
            dist_q <= 32'h0;
            cond_q <= 3'h0;
            ph_q <= 2'b00;
            en_prev_q <= 1'b0;
         end else begin
            en_prev_q <= cf.enable;
            if (cf.cancel_request) begin
               st_q  <= ppo_pkg::ST_IDLE;                       // see [RQ14]
               ptr_q <= '0;
               ph_q  <= 2'b00;
            end else if (!cf.enable) begin
               st_q <= ppo_pkg::ST_IDLE;                        // see [RQ11]
               ph_q <= 2'b00;
            end else begin
               case (st_q)
                  ppo_pkg::ST_IDLE: begin
                     if (start) st_q <= ppo_pkg::ST_WAIT;       // see [RQ8]
                  end
                  ppo_pkg::ST_WAIT: begin
                     if (!own_s2_q[c]) st_q <= ppo_pkg::ST_LOAD; // see [RQ10]
                  end
                  ppo_pkg::ST_LOAD: begin
                     if (ld_fail) begin
                        st_q <= ppo_pkg::ST_IDLE;
                     end else begin
                        st_q   <= ppo_pkg::ST_RUN;
                        half_q <= w_half;
                        hcnt_q <= w_half;
                        dist_q <= w_dist;
                        cond_q <= w_cond[2:0];
                     end
                  end
                  ppo_pkg::ST_RUN: begin
                     if (cf.hold_request) begin
                        st_q <= ppo_pkg::ST_HOLD;               // see [RQ12]
                     end else if (half_tick) begin
                        hcnt_q <= half_q;
                        ph_q   <= ph_q + 2'b01;
                        if (pulse_end) dist_q <= dist_q - 32'h1;
                        if (step_end) begin
                           ptr_q <= last ? '0 : ptr_q + 1'b1;   // see [RQ9]
                           st_q  <= (cond_q[ppo_pkg::COND_CHAIN] && !last) ?
                                    ppo_pkg::ST_LOAD : ppo_pkg::ST_IDLE;
                        end
                     end else begin
                        hcnt_q <= hcnt_q - 32'h1;
                     end
                  end
                  ppo_pkg::ST_HOLD: begin
                     if (!cf.hold_request) st_q <= ppo_pkg::ST_RUN; // see [RQ13]
                  end
                  default: st_q <= ppo_pkg::ST_IDLE;
               endcase
            end
         end
      end

      // sticky flags: a set in the clearing cycle wins
      always_ff @(posedge CLK_IN) begin
         if (!RST_B_IN) begin
            fault_q <= 1'b0;
            done_q  <= 1'b0;
            err_q   <= ppo_pkg::ERR_NONE;
         end else begin
            fault_q <= ld_fail | (fault_q & ~stat_clr[4*c+2]);  // see [RQ16]
            done_q  <= step_end | (done_q & ~stat_clr[4*c+3]);  // see [RQ17]
            if (ld_fail) err_q <= ld_err;
         end
      end

      wire owned = st_q == ppo_pkg::ST_LOAD || st_q == ppo_pkg::ST_RUN ||
                   st_q == ppo_pkg::ST_HOLD;
      assign stat_w[c].pulse_sending_flag = run;                // see [RQ15]
      assign stat_w[c].free = ~owned & ~own_s2_q[c];            // see [RQ18]
      assign stat_w[c].fault = fault_q;
      assign stat_w[c].step_complete_flag = done_q;
      assign err_w[c] = err_q;
      assign ptr_w[c] = 8'(ptr_q);

      wire dir = cond_q[ppo_pkg::COND_DIR];
      wire sq  = ph_q[0];
      wire qa  = ph_q[1];
      wire qb  = ph_q[1] ^ ph_q[0];
      wire active = run || st_q == ppo_pkg::ST_HOLD;
      wire run_a = (cf.mode == ppo_pkg::MODE_UPDOWN) ? sq & ~dir :  // see [RQ19]
                   (cf.mode == ppo_pkg::MODE_QUAD) ? (dir ? qb : qa) : sq;
      wire run_b = (cf.mode == ppo_pkg::MODE_UPDOWN) ? sq & dir :
                   (cf.mode == ppo_pkg::MODE_QUAD) ? (dir ? qa : qb) : dir;
      wire idle_a = cf.pwm_en ? pwm_w[c] : cf.level;            // see [RQ2]
      wire inv_b = cf.idle_hi && cf.mode != ppo_pkg::MODE_PULSEDIR;
      assign pin_d[2*c]   = (active ? run_a : idle_a) ^ cf.idle_hi; // see [RQ20]
      assign pin_d[2*c+1] = (active & run_b) ^ inv_b;
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_B_IN) PULSE_PIN_OUT <= 8'h00;
      else PULSE_PIN_OUT <= pin_d;
   end

   assign S_AXI_AWREADY_OUT = awready_q;
   assign S_AXI_WREADY_OUT  = wready_q;
   assign S_AXI_BVALID_OUT  = bvalid_q;
   assign S_AXI_BRESP_OUT   = bresp_q;
   assign S_AXI_ARREADY_OUT = arready_q;
   assign S_AXI_RVALID_OUT  = rvalid_q;
   assign S_AXI_RDATA_OUT   = rdata_q;
   assign S_AXI_RRESP_OUT   = rresp_q;

endmodule

/* testbench/ppo_sva.sv */
`timescale 1ns/100ps
module ppo_sva (
   input wire logic        CLK_IN, RST_B_IN, S_AXI_AWVALID_IN,
   input wire logic        S_AXI_AWREADY_OUT, S_AXI_WVALID_IN,
   input wire logic        S_AXI_WREADY_OUT, S_AXI_BVALID_OUT,
   input wire logic        S_AXI_BREADY_IN, S_AXI_ARVALID_IN,
   input wire logic        S_AXI_ARREADY_OUT, S_AXI_RVALID_OUT,
   input wire logic        S_AXI_RREADY_IN,
   input wire logic [1:0]  S_AXI_RRESP_OUT,
   input wire logic [31:0] S_AXI_RDATA_OUT
);
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RST_B_IN);
   aw_busy_a: assert property (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT
      |=> !S_AXI_AWREADY_OUT) else $error("aw ready stayed high");
   w_busy_a: assert property (S_AXI_WVALID_IN && S_AXI_WREADY_OUT
      |=> !S_AXI_WREADY_OUT) else $error("w ready stayed high");
   b_answer_a: assert property (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT &&
      S_AXI_WVALID_IN && S_AXI_WREADY_OUT |-> ##2 S_AXI_BVALID_OUT)
      else $error("write response late");
   b_drop_a: assert property (S_AXI_BVALID_OUT && S_AXI_BREADY_IN |=>
      !S_AXI_BVALID_OUT && S_AXI_AWREADY_OUT && S_AXI_WREADY_OUT)
      else $error("write channel not freed");
   b_rise_a: assert property ($rose(S_AXI_BVALID_OUT) |->
      !S_AXI_AWREADY_OUT && !S_AXI_WREADY_OUT) else $error("ready in b");
   r_answer_a: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=>
      S_AXI_RVALID_OUT && !S_AXI_ARREADY_OUT) else $error("read late");
   r_drop_a: assert property (S_AXI_RVALID_OUT && S_AXI_RREADY_IN |=>
      !S_AXI_RVALID_OUT ##0 S_AXI_ARREADY_OUT) else $error("read stuck");
   r_err_a: assert property (S_AXI_RVALID_OUT && S_AXI_RRESP_OUT != 2'b00
      |-> S_AXI_RDATA_OUT == 32'h0) else $error("error read data");
endmodule
bind ppo_pulse_output ppo_sva i_sva (.*);

/* testbench/ppo_drive_model.sv */
`timescale 1ns/100ps
module ppo_drive_model (
   input wire logic       clk_in,     // sample clock
   input wire logic [1:0] pins_in,    // up and down pulse lines
   output int             up_cnt_out  // up pulses taken
);
   logic prev_q = 1'b0;
   initial up_cnt_out = 0;
   always @(posedge clk_in) begin
      prev_q <= pins_in[0];
      if (pins_in[0] && !prev_q) up_cnt_out <= up_cnt_out + 1;
   end
endmodule

/* testbench/ppo_pulse_output_tb_top.sv */
`timescale 1ns/100ps
module ppo_pulse_output_tb_top;
   logic        clk, rst_b, awv, wv, bready, arv, rready;
   logic [13:0] awa, ara;
   logic [31:0] wd, rdata;
   logic [3:0]  owner;
   logic        awr, wrdy, bv, arr, rv;
   logic [1:0]  br, rr;
   logic [7:0]  pins;
   int          bad_count, cmp_count, cyc, up;
   ppo_pulse_output #(.MAX_STEPS(4), .PROG_WORDS(36)) i_dut (
      .CLK_IN(clk), .RST_B_IN(rst_b), .S_AXI_AWADDR_IN(awa),
      .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd),
      .S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrdy),
      .S_AXI_BRESP_OUT(br), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bready),
      .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
      .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rr), .S_AXI_RVALID_OUT(rv),
      .S_AXI_RREADY_IN(rready), .EXT_OWNER_IN(owner), .PULSE_PIN_OUT(pins));
   ppo_drive_model i_drv (.clk_in(clk), .pins_in(pins[1:0]), .up_cnt_out(up));
   task end_sim;
      if (bad_count == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wr(input logic [13:0] a, input logic [31:0] d, input logic [1:0] e);
      awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrdy) wv <= 1'b0;
      end while (!bv);
      bready <= 1'b0;
      chk({30'h0, br}, {30'h0, e});
      @(posedge clk);
   endtask
   task rd(input logic [13:0] a, input logic [31:0] e, input logic [1:0] er);
      ara <= a; arv <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end while (!rv);
      rready <= 1'b0;
      chk(rdata, e);
      chk({30'h0, rr}, {30'h0, er});
      @(posedge clk);
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc > 4000) begin
         bad_count++;
         end_sim;
      end
   end
   initial begin
      rst_b = 0; awv = 0; wv = 0; bready = 0; arv = 0; rready = 0;
      awa = 0; ara = 0; wd = 0; owner = 0; bad_count = 0; cmp_count = 0;
      cyc = 0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd(14'h000, 32'h0, 2'b00);
      rd(14'h004, 32'h0000_2222, 2'b00);
      rd(14'h00c, 32'h0, 2'b00);
      rd(14'h300, 32'h0, 2'b10);
      wr(14'h300, 32'h1, 2'b10);
      wr(14'h400, 32'h2, 2'b00);
      wr(14'h404, 32'h3, 2'b00);
      wr(14'h408, 32'h1, 2'b00);
      wr(14'h000, 32'h11, 2'b00);
      repeat (3) @(posedge clk);
      rd(14'h004, 32'h0000_2221, 2'b00);
      repeat (30) @(posedge clk);
      chk(32'(up), 32'h3);
      rd(14'h004, 32'h0000_222a, 2'b00);
      rd(14'h028, 32'h0, 2'b00);
      owner <= 4'h1;
      wr(14'h000, 32'h0, 2'b00);
      wr(14'h000, 32'h11, 2'b00);
      repeat (30) @(posedge clk);
      chk(32'(up), 32'h3);
      owner <= 4'h0;
      repeat (40) @(posedge clk);
      chk(32'(up), 32'h6);
      wr(14'h000, 32'h100, 2'b00);
      repeat (10) @(posedge clk);
      rd(14'h008, 32'h0000_0400, 2'b00);
      wr(14'h408, 32'h0, 2'b00);
      wr(14'h000, 32'h11, 2'b00);
      repeat (6) @(posedge clk);
      wr(14'h000, 32'h13, 2'b00);
      repeat (20) @(posedge clk);
      chk(32'(up), 32'h8);
      wr(14'h000, 32'h11, 2'b00);
      repeat (30) @(posedge clk);
      chk(32'(up), 32'h9);
      rd(14'h028, 32'h1, 2'b00);
      wr(14'h000, 32'h15, 2'b00);
      rd(14'h028, 32'h0, 2'b00);
      wr(14'h000, 32'h40, 2'b00);
      repeat (2) @(posedge clk);
      chk(32'(up), 32'ha);
      wr(14'h000, 32'h11, 2'b00);
      repeat (6) @(posedge clk);
      wr(14'h000, 32'h10, 2'b00);
      repeat (20) @(posedge clk);
      chk(32'(up), 32'hc);
      end_sim;
   end
endmodule
